// ---- rtl/mps_pkg.sv ----
// Package with register map, field layout, reset values and timing for the segment sequencer
package mps_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int          WB_ADR_W       = 9;
  localparam logic [8:0]  ADR_CONFIG     = 9'h000;
  localparam logic [8:0]  ADR_RANGE      = 9'h004;
  localparam logic [8:0]  ADR_INPUT_CFG  = 9'h008;
  localparam logic [8:0]  ADR_STATUS     = 9'h00C;
  localparam logic [8:0]  ADR_TABLE_BASE = 9'h100;
  localparam logic [1:0]  FLD_DISP       = 2'h0;
  localparam logic [1:0]  FLD_SPEED      = 2'h1;
  localparam logic [1:0]  FLD_ACCEL      = 2'h2;
  localparam logic [1:0]  FLD_WAIT       = 2'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_MODE_LSB  = 0;
  localparam int CFG_RESUME    = 2;
  localparam int CFG_DISP_TYPE = 3;
  localparam int CFG_WAIT_UNIT = 4;
  localparam int RNG_START_LSB = 0;
  localparam int RNG_END_LSB   = 8;
  localparam int INP_SRC_LSB   = 0;
  localparam int INP_RUN_POL   = 8;
  localparam int INP_SEL_LSB   = 9;

  // ----------------------------------------------------------------
  // Encodings and limits
  // ----------------------------------------------------------------
  localparam logic [1:0]  MODE_SINGLE       = 2'h0;
  localparam logic [1:0]  MODE_CYCLIC       = 2'h1;
  localparam logic [1:0]  MODE_SELECT       = 2'h2;
  localparam logic [3:0]  POS_SRC_INTERNAL  = 4'h1;
  localparam logic [4:0]  SEG_FIRST         = 5'h01;
  localparam logic [4:0]  SEG_LAST          = 5'h10;
  localparam logic [31:0] DISP_MIN          = 32'h8000_0001;
  localparam logic [31:0] DISP_MAX          = 32'h7FFF_FFFE;
  localparam logic [12:0] SPEED_MIN         = 13'h0001;
  localparam logic [12:0] SPEED_MAX         = 13'h1388;
  localparam logic [15:0] TIME16_MIN        = 16'h0001;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_DISP    = 32'h0000_2710;
  localparam logic [12:0] RST_SPEED   = 13'h0064;
  localparam logic [15:0] RST_ACCEL   = 16'h0064;
  localparam logic [15:0] RST_WAIT    = 16'h0064;
  localparam logic [3:0]  RST_POS_SRC = 4'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          MS_PERIOD_NS  = 1000000;
  localparam int          MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [9:0]  MS_PER_S_LAST = 10'h3E7;

endpackage

// ---- rtl/mps_sequencer.sv ----
// Multi-segment position sequencer with classic Wishbone register slave
//
// How it works
// - Sequencing runs only in position mode with command source equal to one.
// - Mode 0 steps from start segment to end segment once, then stops.
// - Mode 1 steps start to end and repeats without end.
// - Mode 2 takes each segment number from the four select inputs.
// - Start segment setting holds 1 to 16, default 1.
// - End segment setting holds 1 to 16; automatic modes count upward.
// - Four select inputs form a binary segment code driven by the host.
// - Select code plus one gives the segment number.
// - A select bit reads one when its input sits at its active level.
// - Pause is run enable falling from active to inactive while sequencing.
// - Pause aborts the current segment's remaining motion and stops.
// - Resume policy 0 continues with the segment after the interrupted one.
// - Resume policy 1 restarts from the start segment.
// - Displacement type 0 means relative to current position.
// - Displacement type 1 means absolute from the motor origin.
// - Wait between segments counts milliseconds for unit 0, seconds for unit 1.
// - Displacements are signed, clamped to -2147483647..2147483646, default 10000.
// - Segment top speed is 1 to 5000 rpm, default 100.
// - Short moves may peak below top speed; distance is never overshot.
// - Each segment has a ramp time of 1 to 65535 ms.
// - Each segment has its own wait of 1 to 65535 units.
//
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps

module mps_sequencer
  import mps_pkg::*;
#(
  parameter int MS_CYCLES_P = mps_pkg::MS_CYCLES
)
(
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // Wishbone slave
  input  wire logic                         cyc_i,
  input  wire logic                         stb_i,
  input  wire logic                         we_i,
  input  wire logic [mps_pkg::WB_ADR_W-1:0] adr_i,
  input  wire logic [3:0]                   sel_i,
  input  wire logic [31:0]                  dat_i,
  output logic      [31:0]                  dat_o,
  output logic                              ack_o,
  // Drive state and input terminals
  input  wire logic                         position_mode_i,
  input  wire logic                         segment_run_enable_i,
  input  wire logic [3:0]                   segment_select_bit_i,
  // Motion profile generator
  input  wire logic                         segment_done_i,
  output logic                              segment_start_o,
  output logic                              segment_abort_o,
  output logic      [4:0]                   segment_number_o,
  output logic      [31:0]                  segment_displacement_o,
  output logic      [12:0]                  segment_max_speed_o,
  output logic      [15:0]                  segment_accel_ms_o,
  output logic                              segment_absolute_o,
  output logic                              sequence_active_o,
  output logic                              sequence_done_o
);
  import mps_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_RUN, ST_WAIT, ST_PAUSE, ST_DONE} mps_state_e;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b]) r[8*b +: 8] = wd[8*b +: 8];
    return r;
  endfunction

  function automatic logic [4:0] clamp_seg(input logic [7:0] v);
    if (v < 8'(SEG_FIRST)) return SEG_FIRST;
    if (v > 8'(SEG_LAST))  return SEG_LAST;
    return v[4:0];
  endfunction

  function automatic logic [15:0] clamp_t16(input logic [31:0] v);
    if (v[31:16] != 16'h0000) return '1;
    if (v[15:0] < TIME16_MIN) return TIME16_MIN;
    return v[15:0];
  endfunction

  // ----------------------------------------------------------------
  // Settings and segment table
  // ----------------------------------------------------------------
  logic [1:0]  mode_q;
  logic        resume_q;
  logic        disp_type_q;
  logic        wait_unit_q;
  logic [4:0]  start_seg_q;
  logic [4:0]  end_seg_q;
  logic [3:0]  pos_src_q;
  logic        run_pol_q;
  logic [3:0]  sel_pol_q;
  logic [31:0] disp_q  [16];
  logic [12:0] speed_q [16];
  logic [15:0] accel_q [16];
  logic [15:0] wait_q  [16];

  mps_state_e  state_q;
  logic [4:0]  cur_q;
  logic [15:0] wait_left_q;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic       run_s1_q, run_s2_q, run_prev_q;
  logic [3:0] sel_s1_q, sel_s2_q;
  logic       run_lvl, mode_ok, go, run_fall;
  logic [3:0] sel_lvl;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_s1_q   <= 1'b0;
      run_s2_q   <= 1'b0;
      run_prev_q <= 1'b0;
      sel_s1_q   <= 4'h0;
      sel_s2_q   <= 4'h0;
    end
    else
    begin
      run_s1_q   <= segment_run_enable_i;
      run_s2_q   <= run_s1_q;
      run_prev_q <= run_lvl;
      sel_s1_q   <= segment_select_bit_i;
      sel_s2_q   <= sel_s1_q;
    end
  end

  // Polarity bits give the active level of each terminal
  assign run_lvl  = run_s2_q ^ run_pol_q;
  assign sel_lvl  = sel_s2_q ^ sel_pol_q;
  assign mode_ok  = position_mode_i && (pos_src_q == POS_SRC_INTERNAL);
  assign go       = mode_ok && run_lvl;
  assign run_fall = run_prev_q && !run_lvl;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  logic       req, wr;
  logic       idle_cfg;
  logic [3:0] tidx;
  logic [1:0] tfld;
  logic [31:0] wdisp, wspeed, waccel, wwait;

  assign req      = cyc_i && stb_i && !ack_o;
  assign wr       = req && we_i;
  assign idle_cfg = (state_q == ST_IDLE) || (state_q == ST_DONE);
  assign tidx     = adr_i[7:4];
  assign tfld     = adr_i[3:2];
  assign wdisp    = merge(disp_q[tidx], dat_i, sel_i);
  assign wspeed   = merge({19'h0_0000, speed_q[tidx]}, dat_i, sel_i);
  assign waccel   = merge({16'h0000, accel_q[tidx]}, dat_i, sel_i);
  assign wwait    = merge({16'h0000, wait_q[tidx]}, dat_i, sel_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req;
      dat_o <= 32'h0000_0000;
      if (req && !we_i)
      begin
        if (adr_i[8])
        begin
          if (tfld == FLD_DISP)
            dat_o <= disp_q[tidx];
          else if (tfld == FLD_SPEED)
            dat_o <= {19'h0_0000, speed_q[tidx]};
          else if (tfld == FLD_ACCEL)
            dat_o <= {16'h0000, accel_q[tidx]};
          else
            dat_o <= {16'h0000, wait_q[tidx]};
        end
        else if (adr_i == ADR_CONFIG)
          dat_o <= {27'h000_0000, wait_unit_q, disp_type_q, resume_q, mode_q};
        else if (adr_i == ADR_RANGE)
          dat_o <= {19'h0_0000, end_seg_q, 3'h0, start_seg_q};
        else if (adr_i == ADR_INPUT_CFG)
          dat_o <= {19'h0_0000, sel_pol_q, run_pol_q, 4'h0, pos_src_q};
        else if (adr_i == ADR_STATUS)
          dat_o <= {20'h0_0000, sequence_done_o, state_q == ST_PAUSE, state_q == ST_WAIT,
                    sequence_active_o, 3'h0, cur_q};
      end
    end
  end

  // Operating settings only change while no sequence is in progress, except the run and select polarity bits, which change at any time
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q      <= MODE_SINGLE;
      resume_q    <= 1'b0;
      disp_type_q <= 1'b0;
      wait_unit_q <= 1'b0;
      start_seg_q <= SEG_FIRST;
      end_seg_q   <= SEG_FIRST;
      pos_src_q   <= RST_POS_SRC;
      run_pol_q   <= 1'b0;
      sel_pol_q   <= 4'h0;
    end
    else if (wr && !adr_i[8])
    begin
      if (adr_i == ADR_CONFIG && idle_cfg && sel_i[0])
      begin
        mode_q      <= (dat_i[CFG_MODE_LSB +: 2] > MODE_SELECT) ? MODE_SELECT
                                                                : dat_i[CFG_MODE_LSB +: 2];
        resume_q    <= dat_i[CFG_RESUME];
        disp_type_q <= dat_i[CFG_DISP_TYPE];
        wait_unit_q <= dat_i[CFG_WAIT_UNIT];
      end
      else if (adr_i == ADR_RANGE && idle_cfg)
      begin
        if (sel_i[0]) start_seg_q <= clamp_seg(dat_i[RNG_START_LSB +: 8]);
        if (sel_i[1]) end_seg_q   <= clamp_seg(dat_i[RNG_END_LSB +: 8]);
      end
      else if (adr_i == ADR_INPUT_CFG)
      begin
        if (sel_i[0] && idle_cfg) pos_src_q <= dat_i[INP_SRC_LSB +: 4];
        if (sel_i[1])
        begin
          run_pol_q <= dat_i[INP_RUN_POL];
          sel_pol_q <= dat_i[INP_SEL_LSB +: 4];
        end
      end
    end
  end

  // Segment table takes effect at the next segment load; a wait entry takes effect when its segment finishes and the wait starts
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 16; i++)
      begin
        disp_q[i]  <= RST_DISP;
        speed_q[i] <= RST_SPEED;
        accel_q[i] <= RST_ACCEL;
        wait_q[i]  <= RST_WAIT;
      end
    end
    else if (wr && adr_i[8])
    begin
      if (tfld == FLD_DISP)
      begin
        if (wdisp == 32'h8000_0000)
          disp_q[tidx] <= DISP_MIN;
        else if (wdisp == 32'h7FFF_FFFF)
          disp_q[tidx] <= DISP_MAX;
        else
          disp_q[tidx] <= wdisp;
      end
      else if (tfld == FLD_SPEED)
      begin
        if (wspeed < 32'(SPEED_MIN))
          speed_q[tidx] <= SPEED_MIN;
        else if (wspeed > 32'(SPEED_MAX))
          speed_q[tidx] <= SPEED_MAX;
        else
          speed_q[tidx] <= wspeed[12:0];
      end
      else if (tfld == FLD_ACCEL)
        accel_q[tidx] <= clamp_t16(waccel);
      else
        wait_q[tidx] <= clamp_t16(wwait);
    end
  end

  // ----------------------------------------------------------------
  // Wait time base
  // ----------------------------------------------------------------
  logic [31:0] ms_cnt_q;
  logic [9:0]  sec_cnt_q;
  logic        ms_tick, unit_tick;

  assign ms_tick   = (ms_cnt_q == 32'(MS_CYCLES_P - 1));
  assign unit_tick = ms_tick && (!wait_unit_q || sec_cnt_q == MS_PER_S_LAST);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_q != ST_WAIT)
    begin
      ms_cnt_q  <= 32'h0000_0000;
      sec_cnt_q <= 10'h000;
    end
    else
    begin
      ms_cnt_q <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
      if (ms_tick)
        sec_cnt_q <= (sec_cnt_q == MS_PER_S_LAST) ? 10'h000 : sec_cnt_q + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [4:0] nxt_seg;
  logic       at_end;
  logic [3:0] load_idx;

  assign at_end   = (cur_q == end_seg_q) || (cur_q == SEG_LAST);
  assign nxt_seg  = at_end ? start_seg_q : cur_q + 5'h01;
  assign load_idx = (mode_q == MODE_SELECT) ? sel_lvl : 4'(cur_q - 5'h01);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q                <= ST_IDLE;
      cur_q                  <= SEG_FIRST;
      wait_left_q            <= 16'h0000;
      segment_start_o        <= 1'b0;
      segment_abort_o        <= 1'b0;
      segment_number_o       <= SEG_FIRST;
      segment_displacement_o <= 32'h0000_0000;
      segment_max_speed_o    <= 13'h0000;
      segment_accel_ms_o     <= 16'h0000;
      segment_absolute_o     <= 1'b0;
    end
    else
    begin
      segment_start_o <= 1'b0;
      segment_abort_o <= 1'b0;
      case (state_q)
        ST_IDLE:
          if (go)
          begin
            cur_q   <= start_seg_q;
            state_q <= ST_LOAD;
          end
        ST_LOAD:
          if (!go)
            state_q <= ST_PAUSE;
          else
          begin
            cur_q                  <= 5'(load_idx) + 5'h01;
            segment_number_o       <= 5'(load_idx) + 5'h01;
            // Whole displacement goes out; the profile lowers peak speed on short moves
            segment_displacement_o <= disp_q[load_idx];
            segment_max_speed_o    <= speed_q[load_idx];
            segment_accel_ms_o     <= accel_q[load_idx];
            segment_absolute_o     <= disp_type_q;
            segment_start_o        <= 1'b1;
            state_q                <= ST_RUN;
          end
        ST_RUN:
          if (!go)
          begin
            segment_abort_o <= 1'b1;
            state_q         <= ST_PAUSE;
          end
          else if (segment_done_i)
          begin
            if (mode_q == MODE_SINGLE && at_end)
              state_q <= ST_DONE;
            else
            begin
              wait_left_q <= wait_q[4'(cur_q - 5'h01)];
              state_q     <= ST_WAIT;
            end
          end
        ST_WAIT:
          if (!go)
            state_q <= ST_PAUSE;
          else if (unit_tick)
          begin
            wait_left_q <= wait_left_q - 16'h0001;
            if (wait_left_q == 16'h0001)
            begin
              cur_q   <= nxt_seg;
              state_q <= ST_LOAD;
            end
          end
        ST_PAUSE:
          if (go)
          begin
            if (resume_q)
            begin
              cur_q   <= start_seg_q;
              state_q <= ST_LOAD;
            end
            else if (mode_q == MODE_SINGLE && at_end)
              state_q <= ST_DONE;
            else
            begin
              cur_q   <= nxt_seg;
              state_q <= ST_LOAD;
            end
          end
        ST_DONE:
          if (!run_lvl)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  assign sequence_active_o = (state_q != ST_IDLE) && (state_q != ST_DONE);
  assign sequence_done_o   = (state_q == ST_DONE);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [31:0] wait_cyc_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_q != ST_WAIT)
      wait_cyc_q <= 32'h0000_0000;
    else
      wait_cyc_q <= wait_cyc_q + 32'h0000_0001;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_START_NEEDS_MODE: assert property ($rose(segment_start_o) |-> $past(mode_ok))
    else $error("segment started outside internal position mode");
  AST_SINGLE_STOPS: assert property (sequence_done_o |-> !segment_start_o)
    else $error("segment started after single pass ended");
  AST_SELECT_DECODE: assert property (
    segment_start_o && mode_q == MODE_SELECT |-> segment_number_o == 5'($past(sel_lvl)) + 5'h01)
    else $error("selected segment number does not match select code");
  AST_AUTO_RANGE: assert property (
    segment_start_o && mode_q != MODE_SELECT && start_seg_q <= end_seg_q
    |-> segment_number_o >= start_seg_q && segment_number_o <= end_seg_q)
    else $error("automatic segment outside start..end");
  AST_PAUSE_ABORTS: assert property (
    state_q == ST_RUN && run_fall && mode_ok |=> segment_abort_o && state_q == ST_PAUSE)
    else $error("pause did not abort the running segment");
  AST_RESUME_START: assert property (
    state_q == ST_PAUSE && go && resume_q && mode_q != MODE_SELECT
    |=> (cur_q == start_seg_q) and (go |=> segment_start_o && segment_number_o == start_seg_q))
    else $error("resume did not restart at start segment");
  AST_WAIT_LENGTH: assert property (
    state_q == ST_LOAD && $past(state_q) == ST_WAIT
    |-> $past(wait_cyc_q) >= 32'(MS_CYCLES_P - 1))
    else $error("inter-segment wait shorter than one unit");
  AST_ABS_FLAG: assert property (segment_start_o |-> segment_absolute_o == disp_type_q)
    else $error("displacement type not passed with segment");
  AST_SPEED_LIMIT: assert property (
    segment_start_o |-> segment_max_speed_o >= SPEED_MIN && segment_max_speed_o <= SPEED_MAX)
    else $error("segment speed outside 1..5000");

  COV_PAUSE: cover property (segment_abort_o);
  COV_CYCLIC_WRAP: cover property (
    state_q == ST_WAIT && mode_q == MODE_CYCLIC && at_end ##[1:1000] segment_start_o);
  COV_SELECT_RUN: cover property (segment_start_o && mode_q == MODE_SELECT);
  COV_SINGLE_DONE: cover property ($rose(sequence_done_o));

endmodule // mps_sequencer

// ---- tb/mps_host_model.sv ----
// Host controller model driving the run and select terminals
`timescale 1ns/1ps

module mps_host_model (
  // Clock
  input  wire logic       clk_i,
  // Logical levels and terminal polarity
  input  wire logic       run_i,
  input  wire logic [3:0] code_i,
  input  wire logic       run_inv_i,
  input  wire logic [3:0] sel_inv_i,
  // Terminals
  output logic            run_pin_o,
  output logic [3:0]      sel_pin_o
);
  always @(posedge clk_i)
  begin
    run_pin_o <= run_i ^ run_inv_i;
    sel_pin_o <= code_i ^ sel_inv_i;
  end
endmodule // mps_host_model

// ---- tb/multi_segment_position_sequencer_bench.sv ----
// Self-checking bench for the segment sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end

module multi_segment_position_sequencer_bench;
  import mps_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [8:0]  adr_i = 9'h000;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        pos = 1'b1;
  logic        run = 1'b0;
  logic [3:0]  code = 4'h0;
  logic        rinv = 1'b0;
  logic [3:0]  sinv = 4'h0;
  logic        rpin;
  logic [3:0]  spin;
  logic        done_i = 1'b0;
  logic        start_o;
  logic        abort_o;
  logic        abs_o;
  logic        sdone_o;
  logic [4:0]  num_o;
  logic [31:0] disp_o;
  logic [4:0]  dcnt = 5'h00;
  logic [31:0] rnd;
  int          errors = 0;
  int          cmp_count = 0;
  int          aborts = 0;
  logic [31:0] rdq[$];
  logic [37:0] sq[$];
  logic [3:0]  sel = 4'hF;
  logic [12:0] spd_o;
  logic [15:0] acc_o;
  logic        act_o;
  logic [31:0] exp_rd;
  logic [37:0] exp_seg;
  int          cyc_n = 0;
  int          last_start = 0;
  int          gap = 0;
  localparam int MS_SIM = 4;
  localparam int GAP_MS = int'(RST_WAIT) * MS_SIM;
  localparam int GAP_S  = (int'(MS_PER_S_LAST) + 1) * MS_SIM;

  mps_host_model u_host (.clk_i(clk_i), .run_i(run), .code_i(code), .run_inv_i(rinv),
    .sel_inv_i(sinv), .run_pin_o(rpin), .sel_pin_o(spin));

  mps_sequencer #(.MS_CYCLES_P(MS_SIM)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .position_mode_i(pos), .segment_run_enable_i(rpin),
    .segment_select_bit_i(spin), .segment_done_i(done_i), .segment_start_o(start_o),
    .segment_abort_o(abort_o), .segment_number_o(num_o), .segment_displacement_o(disp_o),
    .segment_max_speed_o(spd_o), .segment_accel_ms_o(acc_o), .segment_absolute_o(abs_o),
    .sequence_active_o(act_o), .sequence_done_o(sdone_o));

  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i iff ack_o === 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    rdq.push_back(e);
    wb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    run <= 1'b0;
    rinv <= 1'b0;
    sinv <= 4'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic pause_run(input int n);
    while (sq.size() != 0)
      @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    run <= 1'b0;
    repeat (30) @(posedge clk_i);
    `CHK(aborts, n)
    `CHK(act_o, 1'b1)
  endtask

  task automatic stop_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Profile generator stand-in and output watcher
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    dcnt <= start_o ? 5'h14 : (dcnt != 5'h00 ? dcnt - 5'h01 : 5'h00);
    done_i <= (dcnt == 5'h01);
    cyc_n++;
    if (ack_o === 1'b1 && !we_i)
    begin
      exp_rd = rdq.pop_front();
      `CHK(dat_o, exp_rd)
    end
    if (start_o === 1'b1)
    begin
      gap = cyc_n - last_start;
      last_start = cyc_n;
      `CHK({spd_o, acc_o}, {RST_SPEED, RST_ACCEL})
      if (sq.size() == 0)
        `CHK(1'b1, 1'b0)
      else
      begin
        exp_seg = sq.pop_front();
        `CHK({abs_o, num_o, disp_o}, exp_seg)
      end
    end
    if (abort_o === 1'b1)
      aborts++;
  end

  initial
  begin
    void'($urandom(32'hee71b098));
    fork
      begin
        repeat (20000) @(posedge clk_i);
        errors++;
        stop_test();
      end
    join_none
    do_reset();
    rd(ADR_RANGE, 32'h0000_0101);
    rd(ADR_TABLE_BASE, RST_DISP);
    rd(9'h014, 32'h0000_0000);
    wb(1'b1, 9'h104, 32'h0000_1770);
    rd(9'h104, {19'h0_0000, SPEED_MAX});
    sel <= 4'h1;
    wb(1'b1, 9'h104, 32'hFFFF_FF05);
    sel <= 4'hF;
    rd(9'h104, {19'h0_0000, SPEED_MAX[12:8], 8'h05});
    wb(1'b1, ADR_TABLE_BASE, 32'h8000_0000);
    rd(ADR_TABLE_BASE, DISP_MIN);
    $display("test registers done");
    rnd = $urandom & 32'h3FFF_FFFF;
    pos <= 1'b0;
    wb(1'b1, ADR_RANGE, 32'h0000_0403);
    wb(1'b1, ADR_CONFIG, 32'h0000_0018);
    wb(1'b1, 9'h120, rnd);
    wb(1'b1, 9'h12C, 32'h0000_0001);
    run <= 1'b1;
    wb(1'b1, ADR_INPUT_CFG, 32'h0000_0001);
    repeat (20) @(posedge clk_i);
    sq.push_back({1'b1, 5'h03, rnd});
    sq.push_back({1'b1, 5'h04, RST_DISP});
    pos <= 1'b1;
    while (sdone_o !== 1'b1)
      @(posedge clk_i);
    repeat (40) @(posedge clk_i);
    `CHK(sq.size(), 0)
    `CHK({sdone_o, act_o}, 2'b10)
    `CHK(gap >= GAP_S + 20 && gap <= GAP_S + 40, 1'b1)
    $display("test single done");
    for (int p = 0; p < 2; p++)
    begin
      do_reset();
      rinv <= 1'b1;
      wb(1'b1, ADR_RANGE, 32'h0000_100F);
      wb(1'b1, ADR_CONFIG, {29'h0000_0000, p[0], 2'h1});
      wb(1'b1, ADR_INPUT_CFG, 32'h0000_0101);
      sq.push_back({1'b0, 5'h0F, RST_DISP});
      sq.push_back({1'b0, 5'h10, RST_DISP});
      sq.push_back({1'b0, 5'h0F, RST_DISP});
      run <= 1'b1;
      pause_run(2 * p + 1);
      `CHK(gap >= GAP_MS + 20 && gap <= GAP_MS + 40, 1'b1)
      rd(ADR_STATUS, 32'h0000_050F);
      sq.push_back({1'b0, p[0] ? 5'h0F : 5'h10, RST_DISP});
      run <= 1'b1;
      pause_run(2 * p + 2);
    end
    $display("test cyclic done");
    do_reset();
    rnd = $urandom;
    code <= rnd[3:0];
    sinv <= 4'hF;
    wb(1'b1, ADR_CONFIG, 32'h0000_0006);
    wb(1'b1, ADR_INPUT_CFG, 32'h0000_1E01);
    sq.push_back({1'b0, {1'b0, rnd[3:0]} + 5'h01, RST_DISP});
    run <= 1'b1;
    while (sq.size() != 0)
      @(posedge clk_i);
    code <= ~rnd[3:0];
    sq.push_back({1'b0, {1'b0, ~rnd[3:0]} + 5'h01, RST_DISP});
    pause_run(5);
    $display("test select done");
    stop_test();
  end
endmodule // multi_segment_position_sequencer_bench
